// >>> src/irq_prio_pkg.sv
/*
 holds register indices, reset values, write masks, request slot
 numbers, field codes and bus constants for the priority level block.
 assumes a single clock domain and a 32-bit ahb-lite register bus.
*/
package irq_prio_pkg;

   // ****************************************************************
   // register map (index, byte address is four times the index)
   // ****************************************************************
   localparam int unsigned DATA_W = 16;
   localparam int unsigned REG_COUNT = 3;
   localparam int unsigned FIELDS_PER_REG = 8;
   localparam int unsigned SLOT_COUNT = 24;
   localparam logic [3:0] IDX_TIMER_AB_C = 4'h7;
   localparam logic [3:0] IDX_SERIAL0_TIMER_A = 4'h8;
   localparam logic [3:0] IDX_MOTOR_CONVERTER = 4'h9;
   localparam logic [3:0] IDX_NONE = 4'h0;
   localparam logic [15:0] RST_TIMER_AB_C = 16'h0000;
   localparam logic [15:0] RST_SERIAL0_TIMER_A = 16'h0000;
   localparam logic [15:0] RST_MOTOR_CONVERTER = 16'h0000;
   localparam logic [15:0] WMASK_TIMER_AB_C = 16'hffff;
   localparam logic [15:0] WMASK_SERIAL0_TIMER_A = 16'hf3ff;
   localparam logic [15:0] WMASK_MOTOR_CONVERTER = 16'hffff;

   // ****************************************************************
   // request slots: register order times eight plus field lsb over two
   // ****************************************************************
   localparam int unsigned TIMER_C_CH1_SLOT = 0;
   localparam int unsigned TIMER_C_CH2_SLOT = 1;
   localparam int unsigned TIMER_C_CH3_SLOT = 2;
   localparam int unsigned TIMER_B_CH0_SLOT = 3;
   localparam int unsigned TIMER_B_CH1_SLOT = 4;
   localparam int unsigned TIMER_B_CH2_SLOT = 5;
   localparam int unsigned TIMER_B_CH3_SLOT = 6;
   localparam int unsigned TIMER_A_CH0_SLOT = 7;
   localparam int unsigned TIMER_A_CH1_SLOT = 8;
   localparam int unsigned TIMER_A_CH2_SLOT = 9;
   localparam int unsigned TIMER_A_CH3_SLOT = 10;
   localparam int unsigned SERIAL0_TX_EMPTY_SLOT = 11;
   localparam int unsigned SERIAL0_TX_IDLE_SLOT = 12;
   localparam int unsigned SERIAL0_RSVD_SLOT = 13;
   localparam int unsigned SERIAL0_RX_ERROR_SLOT = 14;
   localparam int unsigned SERIAL0_RX_FULL_SLOT = 15;
   localparam int unsigned CONV_B_COMPLETE_SLOT = 16;
   localparam int unsigned CONV_A_COMPLETE_SLOT = 17;
   localparam int unsigned CONV_B_ZERO_CROSS_SLOT = 18;
   localparam int unsigned CONV_A_ZERO_CROSS_SLOT = 19;
   localparam int unsigned PWM_B_RELOAD_SLOT = 20;
   localparam int unsigned PWM_A_RELOAD_SLOT = 21;
   localparam int unsigned PWM_B_FAULT_SLOT = 22;
   localparam int unsigned PWM_A_FAULT_SLOT = 23;

   // ****************************************************************
   // field codes and levels
   // ****************************************************************
   localparam logic [1:0] CODE_OFF = 2'h0;
   localparam logic [1:0] CODE_L0 = 2'h1;
   localparam logic [1:0] CODE_L1 = 2'h2;
   localparam logic [1:0] CODE_L2 = 2'h3;
   localparam logic [1:0] LEVEL_0 = 2'h0;
   localparam logic [1:0] LEVEL_1 = 2'h1;
   localparam logic [1:0] LEVEL_2 = 2'h2;

   // ****************************************************************
   // bus constants
   // ****************************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef struct packed {
      logic en;
      logic [1:0] lvl;
   } prio_t;

   // field code to enable and level, never above level 2
   function automatic prio_t field_level(input logic [1:0] code);
      prio_t p;
      p.en = 1'b0;
      p.lvl = LEVEL_0;
      case (code)
         CODE_L0: begin
            p.en = 1'b1;
            p.lvl = LEVEL_0;
         end
         CODE_L1: begin
            p.en = 1'b1;
            p.lvl = LEVEL_1;
         end
         CODE_L2: begin
            p.en = 1'b1;
            p.lvl = LEVEL_2;
         end
         default: begin
            p.en = 1'b0;
            p.lvl = LEVEL_0;
         end
      endcase
      return p;
   endfunction

endpackage

// >>> src/reg_access_if.sv
/*
 holds the register access interface between the bus port and the
 register file. assumes one clock; wr_en is a one-cycle strobe.
*/
`timescale 1ns/1ps
interface reg_access_if;
   logic wr_en;
   logic [3:0] idx;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport bus (output wr_en, output idx, output wdata, input rdata);
   modport regs (input wr_en, input idx, input wdata, output rdata);
endinterface

// >>> src/ahb_reg_port.sv
/*
 holds the ahb-lite slave that turns single word transfers into
 register strobes. assumes it is the only slave, so hready is its own
 hreadyout; every transfer gets one wait state.
*/
`timescale 1ns/1ps
module ahb_reg_port (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   reg_access_if.bus bus
);

   typedef struct packed {
      logic pend;
      logic write;
      logic [3:0] idx;
      logic ready;
      logic [31:0] rdata;
   } port_t;

   port_t st_q;
   port_t st_d;
   logic mapped;

   // ****************************************************************
   // address phase decode and data phase
   // ****************************************************************
   always_comb begin
      st_d = st_q;
      mapped = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0)
         && (hsize == irq_prio_pkg::HSIZE_WORD);
      bus.idx = st_q.idx;
      bus.wdata = hwdata[15:0];
      bus.wr_en = st_q.pend & st_q.write;
      if (st_q.pend) begin
         st_d.pend = 1'b0;
         st_d.ready = 1'b1;
         st_d.rdata = st_q.write ? 32'h0 : {16'h0, bus.rdata};
      end
      if (hready && hsel && htrans == irq_prio_pkg::HTRANS_NONSEQ) begin
         st_d.pend = 1'b1;
         st_d.ready = 1'b0;
         st_d.write = hwrite;
         st_d.idx = mapped ? haddr[5:2] : irq_prio_pkg::IDX_NONE;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '{pend: 1'b0, write: 1'b0, idx: 4'h0, ready: 1'b1, rdata: 32'h0};
      end else begin
         st_q <= st_d;
      end
   end

   assign hreadyout = st_q.ready;
   assign hresp = irq_prio_pkg::HRESP_OKAY;
   assign hrdata = st_q.rdata;

endmodule

// >>> src/prio_field_decode.sv
/*
 holds the decode of one 2-bit priority field into enable and level.
 assumes the field comes from a register flip-flop.
*/
`timescale 1ns/1ps
module prio_field_decode (
   input wire logic [1:0] code,
   output logic en,
   output logic [1:0] lvl
);

   irq_prio_pkg::prio_t p;

   always_comb begin
      p = irq_prio_pkg::field_level(code);
      en = p.en;
      lvl = p.lvl;
   end

endmodule

// >>> src/irq_priority_level_regs.sv
/*
 holds the three priority registers, their bus port and the gating of
 peripheral requests into levels for the arbitration logic.
 assumes requests are synchronous levels on clk and that arbitration
 samples the registered outputs.
*/
// What this block does
// RULE1 - field code 00 blocks its request from arbitration entirely
// RULE2 - field code 01 presents the request at level 0
// RULE3 - field code 10 presents the request at level 1
// RULE4 - field code 11 presents the request at level 2
// RULE5 - no field encoding yields a level above 2
// RULE6 - reset clears all three registers, disabling every request
// RULE7 - first register holds timer a ch0, timer b ch3-0, timer c ch3-1
// RULE8 - second register holds serial 0 events and timer a ch3-1
// RULE9 - second register bits 11 and 10 read zero, writes ignored
// RULE10 - third register upper byte holds pwm faults and reloads
// RULE11 - third register lower byte holds converter events
// RULE12 - registers are whole words at consecutive offsets, read back
`timescale 1ns/1ps
module irq_priority_level_regs (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [23:0] src_irq,
   output logic [23:0] req_out,
   output logic [23:0] req_enabled,
   output logic [2:0] level_pending,
   output logic top_valid,
   output logic [1:0] top_level,
   output logic [1:0] timer_a_ch0_level,
   output logic [1:0] timer_b_ch3_level,
   output logic [1:0] timer_b_ch2_level,
   output logic [1:0] timer_b_ch1_level,
   output logic [1:0] timer_b_ch0_level,
   output logic [1:0] timer_c_ch3_level,
   output logic [1:0] timer_c_ch2_level,
   output logic [1:0] timer_c_ch1_level,
   output logic [1:0] serial0_rx_full_level,
   output logic [1:0] serial0_rx_error_level,
   output logic [1:0] serial0_tx_idle_level,
   output logic [1:0] serial0_tx_empty_level,
   output logic [1:0] timer_a_ch3_level,
   output logic [1:0] timer_a_ch2_level,
   output logic [1:0] timer_a_ch1_level,
   output logic [1:0] pwm_a_fault_level,
   output logic [1:0] pwm_b_fault_level,
   output logic [1:0] pwm_a_reload_level,
   output logic [1:0] pwm_b_reload_level,
   output logic [1:0] conv_a_zero_cross_level,
   output logic [1:0] conv_b_zero_cross_level,
   output logic [1:0] conv_a_complete_level,
   output logic [1:0] conv_b_complete_level
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [15:0] timer_ab_c_priority;
      logic [15:0] serial0_timer_a_priority;
      logic [15:0] motor_converter_priority;
      logic [23:0] req;
      logic [23:0] en;
      logic [47:0] lvl;
      logic [2:0] pend;
      logic top_vld;
      logic [1:0] top_lvl;
   } regs_t;

   regs_t st_q;
   regs_t st_d;
   reg_access_if acc ();
   logic [47:0] fields;
   logic [23:0] dec_en;
   logic [47:0] dec_lvl;
   logic [2:0] reg_sel;

   // ****************************************************************
   // register decode
   // ****************************************************************
   function automatic logic [2:0] reg_hit(input logic [3:0] idx);
      logic [2:0] hit;
      hit = 3'h0;
      case (idx)
         irq_prio_pkg::IDX_TIMER_AB_C: begin
            hit = 3'h1;
         end
         irq_prio_pkg::IDX_SERIAL0_TIMER_A: begin
            hit = 3'h2;
         end
         irq_prio_pkg::IDX_MOTOR_CONVERTER: begin
            hit = 3'h4;
         end
         default: begin
            hit = 3'h0;
         end
      endcase
      return hit;
   endfunction

   assign reg_sel = reg_hit(acc.idx);

   // ****************************************************************
   // bus port
   // ****************************************************************
   ahb_reg_port u_port (
      .clk(clk),
      .resetn(resetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .bus(acc.bus)
   );

   // ****************************************************************
   // read back
   // ****************************************************************
   // RULE12 word read back
   always_comb begin
      case (reg_sel)
         3'h1: begin
            acc.rdata = st_q.timer_ab_c_priority;
         end
         // RULE9 reserved reads zero
         3'h2: begin
            acc.rdata = st_q.serial0_timer_a_priority
               & irq_prio_pkg::WMASK_SERIAL0_TIMER_A;
         end
         3'h4: begin
            acc.rdata = st_q.motor_converter_priority;
         end
         default: begin
            acc.rdata = 16'h0000;
         end
      endcase
   end

   // ****************************************************************
   // field decode, slot = register order * 8 + field lsb / 2
   // ****************************************************************
   // RULE7 first register layout
   // RULE8 second register layout
   // RULE10 third register upper byte
   // RULE11 third register lower byte
   assign fields = {st_q.motor_converter_priority,
      st_q.serial0_timer_a_priority, st_q.timer_ab_c_priority};

   for (genvar s = 0; s < irq_prio_pkg::SLOT_COUNT; s++) begin : g_dec
      prio_field_decode u_dec (
         .code(fields[2*s +: 2]),
         .en(dec_en[s]),
         .lvl(dec_lvl[2*s +: 2])
      );
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_d = st_q;
      // RULE12 whole word writes
      if (acc.wr_en) begin
         case (reg_sel)
            3'h1: begin
               st_d.timer_ab_c_priority = acc.wdata
                  & irq_prio_pkg::WMASK_TIMER_AB_C;
            end
            // RULE9 reserved write ignored
            3'h2: begin
               st_d.serial0_timer_a_priority = acc.wdata
                  & irq_prio_pkg::WMASK_SERIAL0_TIMER_A;
            end
            3'h4: begin
               st_d.motor_converter_priority = acc.wdata
                  & irq_prio_pkg::WMASK_MOTOR_CONVERTER;
            end
            default: begin
               st_d.timer_ab_c_priority = st_q.timer_ab_c_priority;
            end
         endcase
      end
      // RULE1 code 00 blocks request
      st_d.en = dec_en;
      st_d.req = dec_en & src_irq;
      // RULE2 code 01 level 0
      // RULE3 code 10 level 1
      // RULE4 code 11 level 2
      st_d.lvl = dec_lvl;
      // RULE5 levels capped at 2
      st_d.pend = 3'h0;
      for (int s = 0; s < irq_prio_pkg::SLOT_COUNT; s++) begin
         if (st_d.req[s]) begin
            case (dec_lvl[2*s +: 2])
               irq_prio_pkg::LEVEL_0: begin
                  st_d.pend[0] = 1'b1;
               end
               irq_prio_pkg::LEVEL_1: begin
                  st_d.pend[1] = 1'b1;
               end
               default: begin
                  st_d.pend[2] = 1'b1;
               end
            endcase
         end
      end
      st_d.top_vld = |st_d.pend;
      if (st_d.pend[2]) begin
         st_d.top_lvl = irq_prio_pkg::LEVEL_2;
      end else if (st_d.pend[1]) begin
         st_d.top_lvl = irq_prio_pkg::LEVEL_1;
      end else begin
         st_d.top_lvl = irq_prio_pkg::LEVEL_0;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // RULE6 reset disables all
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q.timer_ab_c_priority <= irq_prio_pkg::RST_TIMER_AB_C;
         st_q.serial0_timer_a_priority <= irq_prio_pkg::RST_SERIAL0_TIMER_A;
         st_q.motor_converter_priority <= irq_prio_pkg::RST_MOTOR_CONVERTER;
         st_q.req <= 24'h0;
         st_q.en <= 24'h0;
         st_q.lvl <= 48'h0;
         st_q.pend <= 3'h0;
         st_q.top_vld <= 1'b0;
         st_q.top_lvl <= 2'h0;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign req_out = st_q.req;
   assign req_enabled = st_q.en;
   assign level_pending = st_q.pend;
   assign top_valid = st_q.top_vld;
   assign top_level = st_q.top_lvl;
   assign timer_a_ch0_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_A_CH0_SLOT +: 2];
   assign timer_b_ch3_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_B_CH3_SLOT +: 2];
   assign timer_b_ch2_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_B_CH2_SLOT +: 2];
   assign timer_b_ch1_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_B_CH1_SLOT +: 2];
   assign timer_b_ch0_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_B_CH0_SLOT +: 2];
   assign timer_c_ch3_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_C_CH3_SLOT +: 2];
   assign timer_c_ch2_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_C_CH2_SLOT +: 2];
   assign timer_c_ch1_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_C_CH1_SLOT +: 2];
   assign serial0_rx_full_level =
      st_q.lvl[2*irq_prio_pkg::SERIAL0_RX_FULL_SLOT +: 2];
   assign serial0_rx_error_level =
      st_q.lvl[2*irq_prio_pkg::SERIAL0_RX_ERROR_SLOT +: 2];
   assign serial0_tx_idle_level =
      st_q.lvl[2*irq_prio_pkg::SERIAL0_TX_IDLE_SLOT +: 2];
   assign serial0_tx_empty_level =
      st_q.lvl[2*irq_prio_pkg::SERIAL0_TX_EMPTY_SLOT +: 2];
   assign timer_a_ch3_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_A_CH3_SLOT +: 2];
   assign timer_a_ch2_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_A_CH2_SLOT +: 2];
   assign timer_a_ch1_level =
      st_q.lvl[2*irq_prio_pkg::TIMER_A_CH1_SLOT +: 2];
   assign pwm_a_fault_level =
      st_q.lvl[2*irq_prio_pkg::PWM_A_FAULT_SLOT +: 2];
   assign pwm_b_fault_level =
      st_q.lvl[2*irq_prio_pkg::PWM_B_FAULT_SLOT +: 2];
   assign pwm_a_reload_level =
      st_q.lvl[2*irq_prio_pkg::PWM_A_RELOAD_SLOT +: 2];
   assign pwm_b_reload_level =
      st_q.lvl[2*irq_prio_pkg::PWM_B_RELOAD_SLOT +: 2];
   assign conv_a_zero_cross_level =
      st_q.lvl[2*irq_prio_pkg::CONV_A_ZERO_CROSS_SLOT +: 2];
   assign conv_b_zero_cross_level =
      st_q.lvl[2*irq_prio_pkg::CONV_B_ZERO_CROSS_SLOT +: 2];
   assign conv_a_complete_level =
      st_q.lvl[2*irq_prio_pkg::CONV_A_COMPLETE_SLOT +: 2];
   assign conv_b_complete_level =
      st_q.lvl[2*irq_prio_pkg::CONV_B_COMPLETE_SLOT +: 2];

endmodule

// >>> dv/irq_priority_level_regs_asserts.sv
/*
 holds the port checker for the priority level block.
 assumes one clock and an async active-low reset; bound to the top module.
*/
`timescale 1ns/1ps
module irq_prio_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [23:0] src_irq,
   input wire logic [23:0] req_out,
   input wire logic [23:0] req_enabled,
   input wire logic [2:0] level_pending,
   input wire logic [1:0] top_level
);
   // ******************************
   // properties
   // ******************************
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic tk;
   assign tk = hsel && htrans == irq_prio_pkg::HTRANS_NONSEQ && hready;
   property p_ready_wait;
      tk |=> !hreadyout ##1 hreadyout;
   endproperty
   property p_resp_okay;
      hresp == irq_prio_pkg::HRESP_OKAY;
   endproperty
   property p_reset_zero;
      $rose(resetn) |-> req_out == 24'h0 && req_enabled == 24'h0 && hrdata == 32'h0;
   endproperty
   property p_off_blocks;
      (req_out & ~req_enabled) == 24'h0;
   endproperty
   property p_req_src;
      (req_out & ~$past(src_irq)) == 24'h0;
   endproperty
   property p_lvl_cap;
      top_level != 2'h3;
   endproperty
   property p_rsvd_read;
      tk && !hwrite && haddr == 32'h20 |-> ##2 hrdata[11:10] == 2'h0;
   endproperty
   property p_unmapped_read;
      tk && !hwrite && haddr == 32'h28 |-> ##2 hrdata == 32'h0;
   endproperty
   property p_en_needs_write;
      $changed(req_enabled) |-> !$past(hreadyout) || !$past(hreadyout, 2) ||
         !$past(hreadyout, 3);
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("wait state wrong");
   a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
   a_reset_zero: assert property (p_reset_zero) else $error("not clear after reset");
   a_off_blocks: assert property (p_off_blocks) else $error("disabled request passed");
   a_req_src: assert property (p_req_src) else $error("request without source");
   a_lvl_cap: assert property (p_lvl_cap) else $error("level above two");
   a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits set");
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped not zero");
   a_en_needs_write: assert property (p_en_needs_write) else $error("enable moved");
   c_write: cover property (tk && hwrite);
   c_rsvd_read: cover property (tk && !hwrite && haddr == 32'h20);
   c_top_two: cover property (top_level == 2'h2 && level_pending[2]);
endmodule
bind irq_priority_level_regs irq_prio_checker u_irq_prio_checker (.clk, .resetn, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .src_irq, .req_out,
   .req_enabled, .level_pending, .top_level);

// >>> dv/arb_model.sv
/*
 holds a model of the arbitration logic behind the priority block.
 assumes levels come two bits a slot in slot order.
*/
`timescale 1ns/1ps
module arb_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [23:0] req,
   input wire logic [47:0] lv,
   output logic hit,
   output logic [1:0] best
);
   logic [1:0] m;
   always_comb begin
      m = 2'h0;
      for (int s = 0; s < 24; s++) begin
         if (req[s] && lv[2*s+:2] > m) begin
            m = lv[2*s+:2];
         end
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hit <= 1'b0;
         best <= 2'h0;
      end else begin
         hit <= |req;
         best <= m;
      end
   end
endmodule

// >>> dv/test_irq_priority_level_regs.sv
/*
 holds the self-checking bench for the priority level block.
 assumes the design package is compiled first and one bus slave.
*/
`timescale 1ns/1ps
module test_irq_priority_level_regs;
   // ******************************
   // signals
   // ******************************
   typedef struct {string name; logic [63:0] exp;} note_t;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0;
   logic [23:0] src_irq = 24'h0;
   logic rdp = 1'b0;
   logic look = 1'b0;
   logic hreadyout, hresp, top_valid, hit;
   logic [31:0] hrdata;
   logic [23:0] req_out, req_enabled;
   logic [2:0] level_pending;
   logic [1:0] top_level, best;
   wire [47:0] lv;
   note_t q[$];
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [15:0] r [3];
   assign lv[27:26] = 2'h0;
   always #2 clk = ~clk;
   irq_priority_level_regs u_irq_priority_level_regs (.clk, .resetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .src_irq, .req_out, .req_enabled, .level_pending, .top_valid, .top_level,
      .timer_c_ch1_level(lv[1:0]), .timer_c_ch2_level(lv[3:2]), .timer_c_ch3_level(lv[5:4]),
      .timer_b_ch0_level(lv[7:6]), .timer_b_ch1_level(lv[9:8]), .timer_b_ch2_level(lv[11:10]),
      .timer_b_ch3_level(lv[13:12]), .timer_a_ch0_level(lv[15:14]),
      .timer_a_ch1_level(lv[17:16]), .timer_a_ch2_level(lv[19:18]),
      .timer_a_ch3_level(lv[21:20]), .serial0_tx_empty_level(lv[23:22]),
      .serial0_tx_idle_level(lv[25:24]), .serial0_rx_error_level(lv[29:28]),
      .serial0_rx_full_level(lv[31:30]), .conv_b_complete_level(lv[33:32]),
      .conv_a_complete_level(lv[35:34]), .conv_b_zero_cross_level(lv[37:36]),
      .conv_a_zero_cross_level(lv[39:38]), .pwm_b_reload_level(lv[41:40]),
      .pwm_a_reload_level(lv[43:42]), .pwm_b_fault_level(lv[45:44]),
      .pwm_a_fault_level(lv[47:46]));
   arb_model u_arb_model (.clk, .resetn, .req(req_out), .lv, .hit, .best);
   // ******************************
   // tasks
   // ******************************
   task summarize;
      $display("errors %0d checks %0d", err_total, total_checks);
      if (err_total == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task take(input logic [63:0] got);
      note_t n;
      n = q.pop_front();
      total_checks++;
      if (got !== n.exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n.name, n.exp, got);
      end
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= irq_prio_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= irq_prio_pkg::HSIZE_WORD;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      rdp <= !w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rdp <= 1'b0;
   endtask
   task rd(input logic [31:0] a, input logic [15:0] e);
      q.push_back('{"read data", {48'h0, e}});
      xfer(1'b0, a, 32'h0);
   endtask
   task state(input logic [23:0] s);
      logic [47:0] c, le;
      logic [23:0] en, ro;
      logic [2:0] lp;
      logic [1:0] tl;
      c = {r[2], r[1] & 16'hf3ff, r[0]};
      lp = 3'h0;
      for (int k = 0; k < 24; k++) begin
         en[k] = c[2*k+:2] != irq_prio_pkg::CODE_OFF;
         ro[k] = en[k] & s[k];
         le[2*k+:2] = en[k] ? c[2*k+:2] - 2'h1 : 2'h0;
         if (ro[k]) lp[le[2*k+:2]] = 1'b1;
      end
      tl = lp[2] ? 2'h2 : (lp[1] ? 2'h1 : 2'h0);
      src_irq <= s;
      repeat (3) @(posedge clk);
      q.push_back('{"enable and request", {16'h0, en, ro}});
      q.push_back('{"field levels", {16'h0, le}});
      q.push_back('{"pending and top", {55'h0, |lp, tl, |lp, tl, lp}});
      look <= 1'b1;
      @(posedge clk);
      look <= 1'b0;
   endtask
   // ******************************
   // monitor, timeout, sequence
   // ******************************
   always @(posedge clk) begin
      if (rdp && hreadyout === 1'b1) take({32'h0, hrdata});
      if (look) begin
         take({16'h0, req_enabled, req_out});
         take({16'h0, lv});
         take({55'h0, hit, best, top_valid, top_level, level_pending});
      end
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_total++;
         $display("MISMATCH timeout expected done seen hang");
         summarize();
      end
   end
   initial begin
      void'($urandom(71));
      r = '{16'h0, 16'h0, 16'h0};
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      state(24'hffffff);
      for (int i = 0; i < 3; i++) rd(32'h1c + 4 * i, 16'h0);
      for (int it = 0; it < 40; it++) begin
         for (int i = 0; i < 3; i++) begin
            r[i] = 16'($urandom);
            xfer(1'b1, 32'h1c + 4 * i, {16'($urandom), r[i]});
         end
         xfer(1'b1, 32'h28, $urandom);
         xfer(1'b1, 32'h5c + 4 * (it % 3), $urandom);
         for (int i = 0; i < 3; i++) rd(32'h1c + 4 * i, r[i] & (i == 1 ? 16'hf3ff : 16'hffff));
         rd(32'h28, 16'h0);
         rd(32'h5c + 4 * (it % 3), 16'h0);
         state(24'($urandom));
      end
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      r = '{16'h0, 16'h0, 16'h0};
      state(24'hffffff);
      rd(32'h20, 16'h0);
      summarize();
   end
endmodule
